// File: design/atr_recorder.sv
/*
  Alarm-triggered trace recorder: pre/post alarm sample history, sixteen
  stored captures, trigger selection and Avalon-MM register slave.
  Assumes samples, alarms and power-fail arrive synchronous to mclk_i.
*/
// Chosen here: the Avalon-MM slave port and the register addresses.
// Function
// - Idle while graphing or frequency analysis runs, or resume delay is 1.
// - Idle without a host connected, unless in test operation mode.
// - Idle while legacy compatibility mode is selected.
// - Fatal alarms never start a capture.
// - After graphing ends, resume once the delay passes or power cycles.
// - History before the alarm is kept continuously, then post samples.
// - Sixteen captures kept; a new one replaces the oldest.
// - Trigger select zero: every non-fatal alarm triggers.
// - Trigger select set: only the named alarm triggers.
// - Trigger select zero: standard channel set recorded.
// - Selected alarm with its own channel set records that set.
// - Selected alarm without own set records the standard set.
// - Power loss during storage marks the capture incomplete.
// - Clock, process and network receive alarms mark capture uncertain.
`timescale 1ns/10ps
`default_nettype none
module atr_recorder
  import atr_pkg::*;
#(
  parameter int unsigned RESUME_UNIT_CYC_P = RESUME_UNIT_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Drive side
  input wire atr_alarm_t alarm_i,
  input wire logic sample_tick_i,
  input wire atr_sample_t sample_std_i,
  input wire atr_sample_t sample_alt_i,
  input wire logic power_fail_i,
  // Interrupt
  output logic irq_o
);
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_POST = 1'b1
  } atr_state_t;
  typedef struct packed {
    atr_state_t st;
    logic [4:0] wr_slot;
    logic [2:0] pos;
    logic [2:0] post_cnt;
    logic [4:0] nrec;
    logic [5:0] ctrl;
    logic [15:0] delay;
    logic [15:0] trig;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [11:0] rsel;
    logic ack;
    logic [31:0] rdata;
    logic graph_prev;
    atr_meta_t cur;
  } atr_regs_t;

  atr_regs_t q, d;
  atr_sample_t sample_mem [256];
  atr_meta_t meta_mem [32];

  logic bus_req, wr_go, active, resume_busy;
  logic fatal_hit, unsure_hit, dedic_hit, alt_sel;
  logic trig_fire, sample_we, finish, abort, graph_end;
  logic [3:0] irq_set;
  logic [31:0] wmask;
  logic [4:0] rslot;
  logic rec_ok;
  atr_meta_t rmeta;
  atr_sample_t rsamp;
  atr_sample_t wsamp;

  atr_code_match #(
    .N(FATAL_N),
    .CODES(FATAL_CODES),
    .MASKS(FATAL_MASKS)
  ) u_fatal (
    .code_i(alarm_i.code),
    .hit_o(fatal_hit)
  );

  atr_code_match #(
    .N(UNSURE_N),
    .CODES(UNSURE_CODES),
    .MASKS(UNSURE_MASKS)
  ) u_unsure (
    .code_i(alarm_i.code),
    .hit_o(unsure_hit)
  );

  atr_code_match #(
    .N(DEDIC_N),
    .CODES(DEDIC_CODES),
    .MASKS(DEDIC_MASKS)
  ) u_dedic (
    .code_i(q.trig),
    .hit_o(dedic_hit)
  );

  assign graph_end = q.graph_prev & ~q.ctrl[CTL_GRAPH];

  atr_resume_timer #(
    .UNIT_CYC(RESUME_UNIT_CYC_P)
  ) u_resume (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .start_i(graph_end),
    .clear_i(q.ctrl[CTL_REARM]),
    .units_i(q.delay),
    .busy_o(resume_busy)
  );

  assign bus_req = avs_read_i | avs_write_i;
  assign wr_go = avs_write_i & q.ack;
  assign avs_waitrequest_o = bus_req & ~q.ack;
  assign avs_readdata_o = q.rdata;
  assign irq_o = |(q.irq_stat & q.irq_mask);
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

  // Gating conditions
  assign active = ~q.ctrl[CTL_GRAPH] & ~q.ctrl[CTL_ANALYZER]
                  & (q.delay != RESUME_OFF)
                  & (q.ctrl[CTL_HOST] | q.ctrl[CTL_TEST])
                  & ~q.ctrl[CTL_LEGACY]
                  & ~resume_busy;

  // Dedicated set only when one alarm is selected and has its own set
  assign alt_sel = (q.trig != TRIG_ALL) & dedic_hit;
  assign wsamp = alt_sel ? sample_alt_i : sample_std_i;

  assign trig_fire = alarm_i.valid & active & (q.st == ST_IDLE)
                     & ~fatal_hit
                     & ((q.trig == TRIG_ALL)
                        | (q.trig == alarm_i.code));

  // History runs while armed, so samples before the alarm are on hand
  assign sample_we = sample_tick_i
                     & (((q.st == ST_IDLE) & active) | (q.st == ST_POST));
  assign abort = (q.st == ST_POST) & power_fail_i;
  assign finish = (q.st == ST_POST) & ~power_fail_i & sample_tick_i
                  & (q.post_cnt == POST_LAST);

  // Readback slot, counted back from the newest capture
  assign rslot = q.wr_slot - 5'h01 - {1'b0, q.rsel[3:0]};
  assign rec_ok = {1'b0, q.rsel[3:0]} < q.nrec;
  assign rmeta = meta_mem[rslot];
  assign rsamp = sample_mem[{rslot, rmeta.start + q.rsel[6:4]}];

  always_ff @(posedge mclk_i) begin
    if (sample_we) begin
      sample_mem[{q.wr_slot, q.pos}] <= wsamp;
    end
    if (finish) begin
      meta_mem[q.wr_slot] <= '{incomplete: 1'b0, unsure: q.cur.unsure,
                              alt_set: q.cur.alt_set, code: q.cur.code,
                              start: q.pos + 3'h1};
    end else if (abort) begin
      meta_mem[q.wr_slot] <= '{incomplete: 1'b1, unsure: q.cur.unsure,
                              alt_set: q.cur.alt_set, code: q.cur.code,
                              start: q.pos};
    end
  end

  always_comb begin
    d = q;
    irq_set = '0;
    d.graph_prev = q.ctrl[CTL_GRAPH];
    d.ctrl[CTL_REARM] = 1'b0;
    d.ack = bus_req & ~q.ack;
    if (sample_we) begin
      d.pos = q.pos + 3'h1;
    end
    if (alarm_i.valid & fatal_hit) begin
      irq_set[IRQ_FATAL] = 1'b1;
    end
    unique case (q.st)
      ST_IDLE: begin
        if (trig_fire) begin
          d.st = ST_POST;
          d.post_cnt = '0;
          d.cur.code = alarm_i.code;
          d.cur.alt_set = alt_sel;
          d.cur.unsure = unsure_hit;
          d.cur.incomplete = 1'b0;
          d.cur.start = '0;
        end
      end
      ST_POST: begin
        if (abort | finish) begin
          d.st = ST_IDLE;
          d.wr_slot = q.wr_slot + 5'h01;
          d.pos = '0;
          if (q.nrec != NREC_MAX) begin
            d.nrec = q.nrec + 5'h01;
          end
          irq_set[IRQ_DONE] = finish;
          irq_set[IRQ_INCOMPLETE] = abort;
          irq_set[IRQ_UNSURE] = q.cur.unsure;
        end else if (sample_tick_i) begin
          d.post_cnt = q.post_cnt + 3'h1;
        end
      end
    endcase
    if (wr_go) begin
      unique case (avs_address_i)
        OFS_CTRL: d.ctrl = (q.ctrl & ~wmask[5:0]) | (avs_writedata_i[5:0] & wmask[5:0]);
        OFS_RESUME: d.delay = (q.delay & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
        OFS_TRIG: d.trig = (q.trig & ~wmask[15:0]) | (avs_writedata_i[15:0] & wmask[15:0]);
        OFS_IRQ_STAT: d.irq_stat = q.irq_stat & ~(avs_writedata_i[3:0] & wmask[3:0]);
        OFS_IRQ_MASK: d.irq_mask = (q.irq_mask & ~wmask[3:0])
                                   | (avs_writedata_i[3:0] & wmask[3:0]);
        OFS_RSEL: d.rsel = (q.rsel & ~wmask[11:0]) | (avs_writedata_i[11:0] & wmask[11:0]);
        default: begin
        end
      endcase
    end
    // Set wins over a clear in the same cycle
    d.irq_stat = d.irq_stat | irq_set;
    if (avs_read_i & ~q.ack) begin
      d.rdata = '0;
      unique case (avs_address_i)
        OFS_CTRL: d.rdata[5:0] = q.ctrl;
        OFS_RESUME: d.rdata[15:0] = q.delay;
        OFS_TRIG: d.rdata[15:0] = q.trig;
        OFS_STATUS: d.rdata[8:0] = {resume_busy, active, q.st == ST_POST, q.nrec,
                                    alt_sel};
        OFS_IRQ_STAT: d.rdata[3:0] = q.irq_stat;
        OFS_IRQ_MASK: d.rdata[3:0] = q.irq_mask;
        OFS_RSEL: d.rdata[11:0] = q.rsel;
        OFS_RDATA: begin
          if (rec_ok & (q.rsel[11:8] == CH_DIGITAL)) begin
            d.rdata[7:0] = rsamp.digital;
          end else if (rec_ok & ~q.rsel[11]) begin
            d.rdata[15:0] = rsamp.analog[q.rsel[10:8]];
          end
        end
        OFS_RINFO: begin
          if (rec_ok) begin
            d.rdata[20:0] = {1'b1, rmeta.incomplete, rmeta.unsure, rmeta.alt_set,
                             rmeta.code, 1'b0};
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '{st: ST_IDLE, ctrl: CTRL_RST, delay: RESUME_RST, trig: TRIG_ALL,
             default: '0};
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  graph_blocks_a: assert property (q.ctrl[CTL_GRAPH] |-> !trig_fire)
    else $error("capture started while graphing");
  host_gate_a: assert property (
    (!q.ctrl[CTL_HOST] && !q.ctrl[CTL_TEST] && alarm_i.valid && q.st == ST_IDLE)
      |=> q.st == ST_IDLE)
    else $error("capture started without host");
  legacy_gate_a: assert property (q.ctrl[CTL_LEGACY] |-> !trig_fire)
    else $error("capture started in legacy mode");
  fatal_skip_a: assert property (
    (alarm_i.valid && fatal_hit && q.st == ST_IDLE) |=> q.st == ST_IDLE)
    else $error("fatal alarm started a capture");
  resume_hold_a: assert property (
    (graph_end && q.delay > RESUME_OFF && !q.ctrl[CTL_REARM]) |=> !active [*2])
    else $error("recorder resumed before delay");
  post_phase_a: assert property (
    (trig_fire ##1 !power_fail_i [*3])
      |=> q.st == ST_POST && $past(q.st) == ST_POST
          && $past(q.st, 2) == ST_POST && $past(q.st, 3) == ST_POST)
    else $error("post-alarm phase too short");
  ring_full_a: assert property (
    (finish && q.nrec == NREC_MAX)
      |=> q.nrec == NREC_MAX && q.wr_slot == $past(q.wr_slot) + 5'h01)
    else $error("capture count wrong at full ring");
  select_one_a: assert property (
    (trig_fire && q.trig != TRIG_ALL) |-> alarm_i.code == q.trig)
    else $error("wrong alarm triggered capture");
  chan_set_a: assert property (
    trig_fire |=> q.cur.alt_set == $past(alt_sel) && q.cur.code == $past(alarm_i.code))
    else $error("channel set not latched at trigger");
  power_loss_a: assert property (
    abort |=> q.irq_stat[IRQ_INCOMPLETE] && q.st == ST_IDLE)
    else $error("power loss not flagged");
  bus_answer_a: assert property ((bus_req && !q.ack) |=> !avs_waitrequest_o)
    else $error("bus request not answered in one cycle");

  // Flags, counts, latched capture state, gating and resume
  done_flag_a: assert property (finish |=> q.irq_stat[IRQ_DONE])
    else $error("capture done not flagged");
  post_ignore_a: assert property (
    (q.st == ST_POST && alarm_i.valid) |=> q.cur.code == $past(q.cur.code))
    else $error("alarm during post phase changed capture");
  idle_no_sample_a: assert property ((q.st == ST_IDLE && !active) |-> !sample_we)
    else $error("history written while inactive");
  fatal_flag_a: assert property (
    (alarm_i.valid && fatal_hit) |=> q.irq_stat[IRQ_FATAL])
    else $error("fatal alarm not flagged");
  count_step_a: assert property (
    ((abort || finish) && q.nrec != NREC_MAX) |=> q.nrec == $past(q.nrec) + 5'h01)
    else $error("capture count not stepped");
  slot_step_a: assert property (
    (abort || finish) |=> q.wr_slot == $past(q.wr_slot) + 5'h01)
    else $error("write slot not advanced");
  std_set_a: assert property ((trig_fire && q.trig == TRIG_ALL) |=> !q.cur.alt_set)
    else $error("standard set not used with all alarms");
  plain_set_a: assert property ((trig_fire && !dedic_hit) |=> !q.cur.alt_set)
    else $error("dedicated set used without one defined");
  analyzer_blocks_a: assert property (q.ctrl[CTL_ANALYZER] |-> !trig_fire)
    else $error("capture started during analysis");
  resume_off_a: assert property (
    (q.delay == RESUME_OFF && q.st == ST_IDLE) |-> !trig_fire && !sample_we)
    else $error("recorder ran with resume delay of one");
  rearm_clear_a: assert property (q.ctrl[CTL_REARM] |=> !resume_busy)
    else $error("rearm did not end resume wait");
  test_mode_a: assert property (
    (q.ctrl[CTL_TEST] && !q.ctrl[CTL_HOST] && alarm_i.valid && !fatal_hit && active
     && q.st == ST_IDLE && q.trig == TRIG_ALL) |=> q.st == ST_POST)
    else $error("test mode alarm not captured");
  unsure_flag_a: assert property (
    ((abort || finish) && q.cur.unsure) |=> q.irq_stat[IRQ_UNSURE])
    else $error("uncertain capture not flagged");
endmodule
`default_nettype wire

// File: common/atr_pkg.sv
/*
  Package of the alarm-triggered trace recorder: register map, field
  positions, alarm code lists, timing counts and shared types.
  Assumes alarm codes are 16 bits: alarm number in [15:4], detail in [3:0].
*/
package atr_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESUME_UNIT_NS = 1000000;
  localparam int RESUME_UNIT_CYC = RESUME_UNIT_NS / CLK_PERIOD_NS;
  localparam int NUM_REC = 16;
  localparam int NUM_ANALOG = 8;
  localparam logic [2:0] POST_LAST = 3'h3;
  localparam logic [4:0] NREC_MAX = 5'h10;
  localparam logic [15:0] TRIG_ALL = 16'h0000;
  localparam logic [15:0] RESUME_OFF = 16'h0001;
  localparam logic [3:0] CH_DIGITAL = 4'h8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESUME = 8'h04;
  localparam logic [7:0] OFS_TRIG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_RSEL = 8'h18;
  localparam logic [7:0] OFS_RDATA = 8'h1c;
  localparam logic [7:0] OFS_RINFO = 8'h20;
  localparam int CTL_GRAPH = 0;
  localparam int CTL_ANALYZER = 1;
  localparam int CTL_HOST = 2;
  localparam int CTL_TEST = 3;
  localparam int CTL_LEGACY = 4;
  localparam int CTL_REARM = 5;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_INCOMPLETE = 1;
  localparam int IRQ_FATAL = 2;
  localparam int IRQ_UNSURE = 3;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [15:0] RESUME_RST = 16'h0000;
  localparam int FATAL_N = 13;
  localparam logic [FATAL_N-1:0][15:0] FATAL_CODES = {16'h0101, 16'h0120,
    16'h0150, 16'h0160, 16'h0170, 16'h0190, 16'h01a0, 16'h01e0, 16'h01f0,
    16'h0250, 16'h0370, 16'h0700, 16'h8880};
  localparam logic [FATAL_N-1:0][15:0] FATAL_MASKS = {16'hffff, {12{16'hfff0}}};
  localparam int UNSURE_N = 4;
  localparam logic [UNSURE_N-1:0][15:0] UNSURE_CODES = {16'h0130, 16'h0140,
    16'h0340, 16'h0360};
  localparam logic [UNSURE_N-1:0][15:0] UNSURE_MASKS = {4{16'hfff0}};
  localparam int DEDIC_N = 3;
  localparam logic [DEDIC_N-1:0][15:0] DEDIC_CODES = {16'h0100, 16'h0200, 16'h0210};
  localparam logic [DEDIC_N-1:0][15:0] DEDIC_MASKS = {3{16'hfff0}};
  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } atr_alarm_t;
  typedef struct packed {
    logic [NUM_ANALOG-1:0][15:0] analog;
    logic [7:0] digital;
  } atr_sample_t;
  typedef struct packed {
    logic incomplete;
    logic unsure;
    logic alt_set;
    logic [15:0] code;
    logic [2:0] start;
  } atr_meta_t;
endpackage

// File: design/atr_code_match.sv
/*
  Matches an alarm code against a constant list of codes with masks.
  Assumes the list is fixed at elaboration.
*/
`timescale 1ns/10ps
`default_nettype none
module atr_code_match
  import atr_pkg::*;
#(
  parameter int N = 1,
  parameter logic [N-1:0][15:0] CODES = '0,
  parameter logic [N-1:0][15:0] MASKS = '0
) (
  // Code in
  input wire logic [15:0] code_i,
  // Result
  output logic hit_o
);
  always_comb begin
    hit_o = 1'b0;
    for (int i = 0; i < N; i++) begin
      if ((code_i & MASKS[i]) == CODES[i]) begin
        hit_o = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: design/atr_resume_timer.sv
/*
  Counts the resume delay in whole units after the graph function ends.
  Assumes start and clear are single-cycle pulses.
*/
`timescale 1ns/10ps
`default_nettype none
module atr_resume_timer
  import atr_pkg::*;
#(
  parameter int unsigned UNIT_CYC = RESUME_UNIT_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Control
  input wire logic start_i,
  input wire logic clear_i,
  input wire logic [15:0] units_i,
  // Status
  output logic busy_o
);
  typedef struct packed {
    logic busy;
    logic [31:0] cyc;
    logic [15:0] left;
  } atr_tmr_t;
  atr_tmr_t q, d;
  always_comb begin
    d = q;
    if (clear_i) begin
      d.busy = 1'b0;
    end else if (start_i) begin
      d.busy = (units_i != 16'h0000);
      d.left = units_i;
      d.cyc = '0;
    end else if (q.busy) begin
      if (q.cyc == UNIT_CYC - 1) begin
        d.cyc = '0;
        d.left = q.left - 16'h0001;
        d.busy = (q.left != 16'h0001);
      end else begin
        d.cyc = q.cyc + 32'h1;
      end
    end
  end
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign busy_o = q.busy;
endmodule
`default_nettype wire

// File: tb/atr_drive_model.sv
/*
  Drive-side model: alarm pulses, periodic sample ticks, sample data.
  Assumes raise() and power() are called just after a rising edge of mclk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module atr_drive_model
  import atr_pkg::*;
#(
  parameter int TICK_CYC = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // Drive side
  output atr_alarm_t alarm_o,
  output logic tick_o,
  output atr_sample_t std_o,
  output atr_sample_t alt_o,
  output logic pfail_o
);
  int cnt_q;
  initial begin
    alarm_o = '0;
    pfail_o = 1'b0;
  end
  // Fresh random sample data on every clock cycle, tick every TICK_CYC cycles
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= 0;
      tick_o <= 1'b0;
      std_o <= '0;
      alt_o <= '0;
    end else begin
      cnt_q <= (cnt_q == TICK_CYC - 1) ? 0 : cnt_q + 1;
      tick_o <= (cnt_q == TICK_CYC - 1);
      std_o <= {$urandom(), $urandom(), $urandom(), $urandom(), 8'($urandom())};
      alt_o <= ~std_o;
    end
  end
  task automatic raise(input logic [15:0] code);
    alarm_o <= '{valid: 1'b1, code: code};
    @(posedge mclk_i);
    alarm_o.valid <= 1'b0;
  endtask
  // Power-fail level, held until called again
  task automatic power(input logic v);
    pfail_o <= v;
  endtask
endmodule
`default_nettype wire

// File: tb/test_atr_recorder.sv
/*
  Self-checking bench of the trace recorder over Avalon-MM.
  Assumes the drive model supplies alarms and samples.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, exp, got); end end
module test_atr_recorder
  import atr_pkg::*;
;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] adr = '0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic [31:0] wd = '0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdata;
  logic wrq;
  logic irq;
  atr_alarm_t alarm;
  logic tick;
  atr_sample_t sstd;
  atr_sample_t salt;
  logic pfail;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int nrec = 0;
  logic [31:0] rv;
  logic [15:0] code;
  logic [31:0] sup [3] = '{32'h5, 32'h6, 32'h14};

  atr_recorder #(.RESUME_UNIT_CYC_P(4)) DUT (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd_s),
    .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wrq), .alarm_i(alarm),
    .sample_tick_i(tick), .sample_std_i(sstd), .sample_alt_i(salt),
    .power_fail_i(pfail), .irq_o(irq));
  atr_drive_model #(.TICK_CYC(4)) dm (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .alarm_o(alarm), .tick_o(tick),
    .std_o(sstd), .alt_o(salt), .pfail_o(pfail));

  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  function automatic logic [31:0] stat_exp(input int n);
    return 32'h80 | (32'(n > 16 ? 16 : n) << 1);
  endfunction

  // Record info: present, then incomplete, uncertain, channel set, code
  function automatic logic [31:0] info_exp(input logic [2:0] fl, input logic [15:0] c);
    return {11'h000, 1'b1, fl, c, 1'b0};
  endfunction

  task automatic give_verdict();
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // One bus access; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr_s <= w;
    rd_s <= !w;
    @(posedge mclk_i);
    while (wrq !== 1'b0) begin
      @(posedge mclk_i);
    end
    rv = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0);
    `CHK(nm, exp, rv)
  endtask

  // Alarm, then time for four post ticks to complete
  task automatic alarm_wait(input logic [15:0] c);
    dm.raise(c);
    repeat (30) @(posedge mclk_i);
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(75));
    repeat (2) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    chk_rd(OFS_CTRL, 32'h0, "ctrl");
    chk_rd(OFS_TRIG, 32'h0, "trig");
    chk_rd(8'h3c, 32'h0, "unmapped");
    chk_rd(OFS_RDATA, 32'h0, "rdata");
    alarm_wait(16'h0420);
    chk_rd(OFS_STATUS, 32'h0, "status");
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    bus(1'b1, OFS_CTRL, 32'h4);
    code = {8'h04, 8'($urandom())};
    alarm_wait(code);
    nrec++;
    chk_rd(OFS_STATUS, stat_exp(nrec), "status");
    `CHK("irq", 1'b1, irq)
    chk_rd(OFS_RINFO, 32'h100000 | (32'(code) << 1), "rinfo");
    bus(1'b1, OFS_IRQ_STAT, 32'hf);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, OFS_RESUME, 32'h1);
    alarm_wait(16'h0430);
    chk_rd(OFS_STATUS, stat_exp(nrec) & ~32'h80, "status");
    bus(1'b1, OFS_RESUME, 32'h0);
    // Graph, analyzer and legacy each hold the recorder off
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, OFS_CTRL, sup[i]);
      alarm_wait(16'h0431);
      chk_rd(OFS_STATUS, stat_exp(nrec) & ~32'h80, "status");
    end
    bus(1'b1, OFS_RESUME, 32'h3);
    bus(1'b1, OFS_CTRL, 32'h5);
    bus(1'b1, OFS_CTRL, 32'h4);
    chk_rd(OFS_STATUS, 32'h100 | 32'(nrec << 1), "status");
    repeat (20) @(posedge mclk_i);
    chk_rd(OFS_STATUS, stat_exp(nrec), "status");
    // Rearm ends the resume wait at once
    bus(1'b1, OFS_CTRL, 32'h5);
    bus(1'b1, OFS_CTRL, 32'h4);
    bus(1'b1, OFS_CTRL, 32'h24);
    chk_rd(OFS_STATUS, stat_exp(nrec), "status");
    bus(1'b1, OFS_CTRL, 32'h8);
    alarm_wait(16'h0440);
    nrec++;
    chk_rd(OFS_STATUS, stat_exp(nrec), "status");
    bus(1'b1, OFS_IRQ_STAT, 32'hf);
    alarm_wait(16'h0101);
    chk_rd(OFS_STATUS, stat_exp(nrec), "status");
    chk_rd(OFS_IRQ_STAT, 32'h4, "irq_stat");
    bus(1'b1, OFS_TRIG, 32'h0450);
    alarm_wait(16'h0460);
    chk_rd(OFS_STATUS, stat_exp(nrec), "status");
    alarm_wait(16'h0450);
    nrec++;
    chk_rd(OFS_STATUS, stat_exp(nrec), "status");
    bus(1'b1, OFS_TRIG, 32'h0);
    repeat (16) begin
      code = {8'h04, 8'($urandom())};
      alarm_wait(code);
      nrec++;
    end
    chk_rd(OFS_STATUS, stat_exp(nrec), "status");
    chk_rd(OFS_RINFO, 32'h100000 | (32'(code) << 1), "rinfo");
    // Power loss in the post phase leaves an incomplete record
    bus(1'b1, OFS_IRQ_STAT, 32'hf);
    dm.raise(16'h0480);
    dm.power(1'b1);
    repeat (3) @(posedge mclk_i);
    dm.power(1'b0);
    nrec++;
    chk_rd(OFS_RINFO, info_exp(3'h4, 16'h0480), "rinfo");
    chk_rd(OFS_IRQ_STAT, 32'h2, "irq_stat");
    alarm_wait(16'h0130);
    nrec++;
    chk_rd(OFS_RINFO, info_exp(3'h2, 16'h0130), "rinfo");
    chk_rd(OFS_IRQ_STAT, 32'hb, "irq_stat");
    // Selected alarm with its own channel set
    bus(1'b1, OFS_TRIG, 32'h0200);
    alarm_wait(16'h0200);
    nrec++;
    chk_rd(OFS_STATUS, stat_exp(nrec) | 32'h1, "status");
    chk_rd(OFS_RINFO, info_exp(3'h1, 16'h0200), "rinfo");
    give_verdict();
  end
endmodule
`default_nettype wire
